// ==== core/nsp_consts.svh ====
// Address map, field positions and reset values of the memory guard.
`ifndef NSP_CONSTS_SVH
`define NSP_CONSTS_SVH

// Program memory word addresses of the default size variant.
`define NSP_BOOT_START   20'h10000
`define NSP_BOOT_END     20'h10fff
`define NSP_FLASH_WORD_W 16

// Data space byte addresses; start addresses are common to all variants.
`define NSP_IO_START     16'h0000
`define NSP_IO_END       16'h0fff
`define NSP_EE_START     16'h1000
`define NSP_EE_END       16'h17ff
`define NSP_SRAM_START   16'h2000
`define NSP_SRAM_END     16'h3fff

// User signature row size in words (one flash page).
`define NSP_PAGE_WORDS   256

// Lock byte field positions, two bits per section.
`define NSP_LK_APP       0
`define NSP_LK_TBL       2
`define NSP_LK_BOOT      4
`define NSP_LOCK_RESET   8'hff
`define NSP_FUSE_RESET   8'hff

// Production signature row byte indices.
`define NSP_PSIG_LOT     5'h03
`define NSP_PSIG_WAFER   5'h06
`define NSP_PSIG_XCOORD  5'h07
`define NSP_PSIG_YCOORD  5'h08
`define NSP_PSIG_CAL_OSC 5'h09
`define NSP_PSIG_CAL_ADC 5'h0a
`define NSP_PSIG_CAL_SW  5'h0b

// Register offsets on the APB slave.
`define NSP_REG_STATUS   12'h000
`define NSP_REG_LOCK     12'h004
`define NSP_REG_FUSE     12'h008
`define NSP_REG_DEVID    12'h00c

`endif

// ==== core/nsp_pkg.sv ====
// Types shared by the memory guard and its bench.
package nsp_pkg;

  typedef enum logic [2:0] {
    OP_READ       = 3'h0,
    OP_WRITE      = 3'h1,
    OP_ERASE_PAGE = 3'h2,
    OP_ERASE_USER = 3'h3,
    OP_CHIP_ERASE = 3'h4
  } nsp_op_e;

  typedef enum logic [2:0] {
    SP_FLASH = 3'h0,
    SP_USER  = 3'h1,
    SP_PSIG  = 3'h2,
    SP_FUSE  = 3'h3,
    SP_LOCK  = 3'h4
  } nsp_space_e;

  typedef enum logic [1:0] {
    SEC_APP  = 2'h0,
    SEC_TBL  = 2'h1,
    SEC_BOOT = 2'h2,
    SEC_NONE = 2'h3
  } nsp_sect_e;

  typedef enum logic [4:0] {
    S_LOAD     = 5'h01,
    S_IDLE     = 5'h02,
    S_NVM      = 5'h04,
    S_CE_FLASH = 5'h08,
    S_CE_LOCK  = 5'h10
  } nsp_state_e;

  typedef struct packed {
    nsp_state_e st;
    logic [7:0]  lock;
    logic [7:0]  fuse_wdt;
    logic [7:0]  fuse_bod;
    logic [7:0]  fuse_start;
    logic [7:0]  cal_osc;
    logic [7:0]  cal_adc;
    logic        owner;
    logic        ack_cpu;
    logic        ack_prog;
    logic        den_cpu;
    logic        den_prog;
    logic [15:0] rdata;
    logic        nvm_go;
    nsp_op_e     nvm_op;
    nsp_space_e  nvm_space;
    logic [19:0] nvm_addr;
    logic [15:0] nvm_wdata;
    logic [31:0] prdata;
    logic        pslverr;
    logic [7:0]  ds_rdata;
    logic [7:0]  deny_cnt;
  } nsp_state_s;

endpackage : nsp_pkg

// ==== core/nsp_nvm_guard.sv ====
// Section decoding, lock and fuse guard for program and data memories.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`include "nsp_consts.svh"

// What this block does
// - Program memory words are sixteen bits.
// - Application and boot sections have separate locks.
// - Software flash writes only run when fetched from boot.
// - Boot-fetched flash writes may target any word not write-locked.
// - Decode application, table and boot word ranges.
// - Table section tops application, boot-sized, own lock.
// - Reset copies calibration bytes from signature row.
// - Production signature row is read only.
// - Signature row holds device id and serial.
// - User row is one page, read/write by both.
// - Chip erase spares user row; own erase clears.
// - Fuses written only by programmer, software reads.
// - Fuses drive reset sources and startup settings.
// - Lock writes may only tighten protection.
// - Chip erase clears locks after flash erase.
// - Unprogrammed bits read one, programmed read zero.
// - Programmer and software both reach flash.
// - Data space decodes I/O, EEPROM, SRAM regions.
// - Region starts fixed; only ends vary.
// - EEPROM and SRAM ends per variant; gap is reserved.
module nsp_nvm_guard #(
  parameter logic [19:0] BOOT_START = `NSP_BOOT_START,
  parameter logic [19:0] BOOT_END   = `NSP_BOOT_END,
  parameter logic [15:0] EE_END     = `NSP_EE_END,
  parameter logic [15:0] SRAM_END   = `NSP_SRAM_END,
  parameter int          PAGE_WORDS = `NSP_PAGE_WORDS,
  parameter logic [23:0] DEV_ID     = 24'h0a5c37, // Arbitrary value.
  parameter logic [23:0] LOT_NUM    = 24'h000001,
  parameter logic [7:0]  WAFER_NUM  = 8'h01,
  parameter logic [15:0] WAFER_XY   = 16'h0000,
  parameter logic [7:0]  CAL_OSC    = 8'h80,
  parameter logic [7:0]  CAL_ADC    = 8'h80,
  parameter logic [7:0]  CAL_SW     = 8'h80
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                cpu_req,
  input  wire nsp_pkg::nsp_op_e    cpu_op,
  input  wire nsp_pkg::nsp_space_e cpu_space,
  input  wire logic [19:0]         cpu_addr,
  input  wire logic [15:0]         cpu_wdata,
  input  wire logic [19:0]         cpu_fetch_pc,
  output logic                     cpu_ack,
  output logic                     cpu_denied,
  output logic      [15:0]         cpu_rdata,
  input  wire logic                program_debug_port_req,
  input  wire nsp_pkg::nsp_op_e    program_debug_port_op,
  input  wire nsp_pkg::nsp_space_e program_debug_port_space,
  input  wire logic [19:0]         program_debug_port_addr,
  input  wire logic [15:0]         program_debug_port_wdata,
  output logic                     program_debug_port_ack,
  output logic                     program_debug_port_denied,
  output logic      [15:0]         program_debug_port_rdata,
  output logic                     nvm_go,
  output nsp_pkg::nsp_op_e         nvm_op,
  output nsp_pkg::nsp_space_e      nvm_space,
  output logic      [19:0]         nvm_addr,
  output logic      [15:0]         nvm_wdata,
  input  wire logic                nvm_done,
  input  wire logic [15:0]         nvm_rdata,
  output logic      [7:0]          fuse_wdt,
  output logic      [7:0]          fuse_bod,
  output logic      [7:0]          fuse_startup,
  output logic      [7:0]          cal_osc,
  output logic      [7:0]          cal_adc,
  input  wire logic [15:0]         ds_addr,
  input  wire logic                ds_rd,
  input  wire logic                ds_wr,
  input  wire logic [7:0]          ds_io_rdata,
  input  wire logic [7:0]          ds_ee_rdata,
  input  wire logic [7:0]          ds_sram_rdata,
  output logic                     ds_io_sel,
  output logic                     ds_ee_sel,
  output logic                     ds_sram_sel,
  output logic      [7:0]          ds_rdata
);

  // The table section is as large as the boot section and sits below it.
  localparam logic [19:0] TBL_START =
    BOOT_START - (BOOT_END - BOOT_START + 20'h00001);
  localparam logic [19:0] PAGE_LIM = 20'(PAGE_WORDS);

  nsp_pkg::nsp_state_s q;
  nsp_pkg::nsp_state_s next_q;

  logic                r_prog;
  logic                r_valid;
  nsp_pkg::nsp_op_e    r_op;
  nsp_pkg::nsp_space_e r_space;
  logic [19:0]         r_addr;
  logic [15:0]         r_wdata;
  logic                r_boot_fetch;
  logic                r_deny;
  logic                r_local;
  logic [15:0]         r_local_data;
  logic                apb_setup;
  logic                apb_wr;
  logic                ds_reserved;

  // Maps a word address onto its flash section.
  function automatic nsp_pkg::nsp_sect_e sect_of(input logic [19:0] a);
    if (a > BOOT_END)
      return nsp_pkg::SEC_NONE;
    else if (a >= BOOT_START)
      return nsp_pkg::SEC_BOOT;
    else if (a >= TBL_START)
      return nsp_pkg::SEC_TBL;
    else
      return nsp_pkg::SEC_APP;
  endfunction : sect_of

  // A cleared bit is programmed: bit 1 low bars writes, bit 0 low reads.
  function automatic logic lock_blocks(input logic [7:0] lk,
                                       input nsp_pkg::nsp_sect_e s,
                                       input logic wr);
    logic [1:0] f;
    f = 2'h3;
    case (s)
      nsp_pkg::SEC_APP:  f = lk[`NSP_LK_APP +: 2];
      nsp_pkg::SEC_TBL:  f = lk[`NSP_LK_TBL +: 2];
      nsp_pkg::SEC_BOOT: f = lk[`NSP_LK_BOOT +: 2];
      default:           f = 2'h0;
    endcase
    return wr ? ~f[1] : ~f[0];
  endfunction : lock_blocks

  // Contents of the factory row: id, serial and calibration bytes.
  function automatic logic [7:0] psig_byte(input logic [4:0] i);
    case (i)
      5'h00: return DEV_ID[7:0];
      5'h01: return DEV_ID[15:8];
      5'h02: return DEV_ID[23:16];
      5'h03: return LOT_NUM[7:0];
      5'h04: return LOT_NUM[15:8];
      5'h05: return LOT_NUM[23:16];
      5'h06: return WAFER_NUM;
      5'h07: return WAFER_XY[7:0];
      5'h08: return WAFER_XY[15:8];
      5'h09: return CAL_OSC;
      5'h0a: return CAL_ADC;
      5'h0b: return CAL_SW;
      default: return 8'hff;
    endcase
  endfunction : psig_byte

  // The programmer wins when both parties ask; an acked party is skipped.
  always_comb
  begin
    r_prog  = program_debug_port_req && !q.ack_prog;
    r_valid = r_prog || (cpu_req && !q.ack_cpu);
    r_op    = r_prog ? program_debug_port_op : cpu_op;
    r_space = r_prog ? program_debug_port_space : cpu_space;
    r_addr  = r_prog ? program_debug_port_addr : cpu_addr;
    r_wdata = r_prog ? program_debug_port_wdata : cpu_wdata;
    r_boot_fetch = sect_of(cpu_fetch_pc) == nsp_pkg::SEC_BOOT;
  end

  // Access checks on the selected request.
  always_comb
  begin
    r_deny = 1'b0;
    r_local = 1'b1;
    r_local_data = 16'h0000;
    case (r_space)
      nsp_pkg::SP_FLASH:
      begin
        r_local = r_op == nsp_pkg::OP_CHIP_ERASE;
        if (r_op == nsp_pkg::OP_CHIP_ERASE)
          r_deny = !r_prog;
        else if (r_op == nsp_pkg::OP_ERASE_USER)
          r_deny = 1'b1;
        else if (r_op != nsp_pkg::OP_READ)
          r_deny = (!r_prog && !r_boot_fetch)
                   || lock_blocks(q.lock, sect_of(r_addr), 1'b1);
        else
          r_deny = lock_blocks(q.lock, sect_of(r_addr), 1'b0);
      end
      nsp_pkg::SP_USER:
      begin
        r_local = 1'b0;
        r_deny = r_addr >= PAGE_LIM
                 || r_op == nsp_pkg::OP_ERASE_PAGE
                 || r_op == nsp_pkg::OP_CHIP_ERASE;
      end
      nsp_pkg::SP_PSIG:
      begin
        r_deny = r_op != nsp_pkg::OP_READ;
        r_local_data = {8'h00, psig_byte(r_addr[4:0])};
      end
      nsp_pkg::SP_FUSE:
      begin
        r_deny = r_op != nsp_pkg::OP_READ
                 && !(r_op == nsp_pkg::OP_WRITE && r_prog);
        r_deny = r_deny || r_addr[1:0] == 2'h3;
        case (r_addr[1:0])
          2'h0:    r_local_data = {8'h00, q.fuse_wdt};
          2'h1:    r_local_data = {8'h00, q.fuse_bod};
          default: r_local_data = {8'h00, q.fuse_start};
        endcase
      end
      default:
      begin
        r_deny = r_op != nsp_pkg::OP_READ && r_op != nsp_pkg::OP_WRITE;
        r_local_data = {8'h00, q.lock};
      end
    endcase
  end

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;

  // Next-state logic of the whole block.
  always_comb
  begin
    next_q = q;
    next_q.ack_cpu  = 1'b0;
    next_q.ack_prog = 1'b0;
    next_q.den_cpu  = 1'b0;
    next_q.den_prog = 1'b0;
    next_q.nvm_go   = 1'b0;
    // Software may only program lock bits, never release them.
    if (apb_wr && paddr == `NSP_REG_LOCK)
      next_q.lock = next_q.lock & pwdata[7:0];
    case (q.st)
      nsp_pkg::S_LOAD:
      begin
        next_q.cal_osc = psig_byte(`NSP_PSIG_CAL_OSC);
        next_q.cal_adc = psig_byte(`NSP_PSIG_CAL_ADC);
        next_q.st = nsp_pkg::S_IDLE;
      end
      nsp_pkg::S_IDLE:
      begin
        if (r_valid)
        begin
          next_q.owner = r_prog;
          if (r_deny || r_local)
          begin
            next_q.ack_cpu  = !r_prog;
            next_q.ack_prog = r_prog;
            next_q.den_cpu  = !r_prog && r_deny;
            next_q.den_prog = r_prog && r_deny;
            next_q.rdata = r_deny ? 16'h0000 : r_local_data;
            if (r_deny)
              next_q.deny_cnt = q.deny_cnt + 8'h01;
          end
          if (!r_deny && r_local)
          begin
            if (r_space == nsp_pkg::SP_FLASH)
            begin
              next_q.ack_prog = 1'b0;
              next_q.st = nsp_pkg::S_CE_FLASH;
            end
            if (r_space == nsp_pkg::SP_LOCK && r_op == nsp_pkg::OP_WRITE)
              next_q.lock = next_q.lock & r_wdata[7:0];
            if (r_space == nsp_pkg::SP_FUSE && r_op == nsp_pkg::OP_WRITE)
            begin
              case (r_addr[1:0])
                2'h0:    next_q.fuse_wdt = r_wdata[7:0];
                2'h1:    next_q.fuse_bod = r_wdata[7:0];
                default: next_q.fuse_start = r_wdata[7:0];
              endcase
            end
          end
          if (!r_deny)
          begin
            if (!r_local || r_space == nsp_pkg::SP_FLASH)
            begin
              next_q.nvm_go = 1'b1;
              next_q.nvm_op = r_op;
              next_q.nvm_space = r_space;
              next_q.nvm_addr = r_addr;
              next_q.nvm_wdata = r_wdata;
            end
            if (!r_local)
              next_q.st = nsp_pkg::S_NVM;
          end
        end
      end
      nsp_pkg::S_NVM:
      begin
        if (nvm_done)
        begin
          next_q.ack_cpu  = !q.owner;
          next_q.ack_prog = q.owner;
          next_q.rdata = nvm_rdata;
          next_q.st = nsp_pkg::S_IDLE;
        end
      end
      nsp_pkg::S_CE_FLASH:
      begin
        if (nvm_done)
          next_q.st = nsp_pkg::S_CE_LOCK;
      end
      default:
      begin
        // Locks are released only once the flash itself is blank.
        next_q.lock = `NSP_LOCK_RESET;
        next_q.ack_prog = 1'b1;
        next_q.st = nsp_pkg::S_IDLE;
      end
    endcase
    // Read data and error are captured in the setup cycle.
    if (apb_setup)
    begin
      next_q.pslverr = 1'b0;
      if (paddr == `NSP_REG_STATUS)
        next_q.prdata = {16'h0000, q.deny_cnt, 3'h0, q.st};
      else if (paddr == `NSP_REG_LOCK)
        next_q.prdata = {24'h000000, q.lock};
      else if (paddr == `NSP_REG_FUSE)
        next_q.prdata = {8'h00, q.fuse_start, q.fuse_bod, q.fuse_wdt};
      else if (paddr == `NSP_REG_DEVID)
        next_q.prdata = {8'h00, DEV_ID};
      else
      begin
        next_q.prdata = 32'h00000000;
        next_q.pslverr = 1'b1;
      end
    end
    // Reserved data space returns zero on read.
    if (ds_rd)
      next_q.ds_rdata = ds_io_sel ? ds_io_rdata : ds_ee_sel ? ds_ee_rdata
                        : ds_sram_sel ? ds_sram_rdata : 8'h00;
  end

  // State register; fuses and locks reset to the unprogrammed value.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q            <= '0;
      q.st         <= nsp_pkg::S_LOAD;
      q.lock       <= `NSP_LOCK_RESET;
      q.fuse_wdt   <= `NSP_FUSE_RESET;
      q.fuse_bod   <= `NSP_FUSE_RESET;
      q.fuse_start <= `NSP_FUSE_RESET;
    end
    else
      q <= next_q;
  end

  // Data space decode; starts and the I/O end fixed, EEPROM and SRAM ends set by the variant.
  assign ds_io_sel   = (ds_rd || ds_wr) && ds_addr <= `NSP_IO_END;
  assign ds_ee_sel   = (ds_rd || ds_wr) && ds_addr >= `NSP_EE_START
                       && ds_addr <= EE_END;
  assign ds_sram_sel = (ds_rd || ds_wr) && ds_addr >= `NSP_SRAM_START
                       && ds_addr <= SRAM_END;
  assign ds_reserved = !(ds_io_sel || ds_ee_sel || ds_sram_sel);

  // Outputs from the state register; pready tied high, pslverr gated by psel and penable.
  assign pready       = 1'b1;
  assign prdata       = q.prdata;
  assign pslverr      = q.pslverr && psel && penable;
  assign cpu_ack      = q.ack_cpu;
  assign cpu_denied   = q.den_cpu;
  assign cpu_rdata    = q.rdata;
  assign program_debug_port_ack    = q.ack_prog;
  assign program_debug_port_denied = q.den_prog;
  assign program_debug_port_rdata  = q.rdata;
  assign nvm_go       = q.nvm_go;
  assign nvm_op       = q.nvm_op;
  assign nvm_space    = q.nvm_space;
  assign nvm_addr     = q.nvm_addr;
  assign nvm_wdata    = q.nvm_wdata;
  assign fuse_wdt     = q.fuse_wdt;
  assign fuse_bod     = q.fuse_bod;
  assign fuse_startup = q.fuse_start;
  assign cal_osc      = q.cal_osc;
  assign cal_adc      = q.cal_adc;
  assign ds_rdata     = q.ds_rdata;

  // Checks on the guard's own behaviour.
  a_app_fetch_gate: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == nsp_pkg::S_IDLE && r_valid && !r_prog
    && r_space == nsp_pkg::SP_FLASH && r_op == nsp_pkg::OP_WRITE
    && !r_boot_fetch |=> cpu_denied && cpu_ack && !nvm_go)
    else $error("flash write from application fetch was not refused");

  a_psig_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    nvm_go |-> nvm_space != nsp_pkg::SP_PSIG)
    else $error("production row reached the flash controller");

  a_fuse_prog_only: assert property (@(posedge pclk) disable iff (!presetn)
    $changed({fuse_wdt, fuse_bod}) |-> $past(r_prog)
    && $past(q.st) == nsp_pkg::S_IDLE)
    else $error("fuse changed without a programmer write");

  a_lock_only_tight: assert property (@(posedge pclk) disable iff (!presetn)
    $past(q.st) != nsp_pkg::S_CE_LOCK |-> (q.lock & ~$past(q.lock)) == 8'h00)
    else $error("lock bit released outside chip erase");

  a_lock_after_erase: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == nsp_pkg::S_CE_LOCK |-> $past(q.st) == nsp_pkg::S_CE_FLASH
    && $past(nvm_done) ##1 q.lock == `NSP_LOCK_RESET && program_debug_port_ack)
    else $error("locks cleared out of order");

  a_ce_spare_user: assert property (@(posedge pclk) disable iff (!presetn)
    nvm_go && nvm_op == nsp_pkg::OP_CHIP_ERASE
    |-> nvm_space == nsp_pkg::SP_FLASH)
    else $error("chip erase aimed at the user row");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ds_rd && ds_reserved |=> ds_rdata == 8'h00)
    else $error("reserved data read was not zero");

  a_ee_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (ds_rd || ds_wr) && ds_addr >= 16'h1000 && ds_addr <= EE_END
    |-> ds_ee_sel && !ds_io_sel && !ds_sram_sel)
    else $error("EEPROM window decoded wrongly");

  a_cal_loaded: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(q.st == nsp_pkg::S_LOAD) |-> cal_osc == CAL_OSC
    && cal_adc == CAL_ADC ##2 cal_osc == CAL_OSC)
    else $error("calibration not copied at reset");

  a_locked_read: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == nsp_pkg::S_IDLE && r_valid && r_space == nsp_pkg::SP_FLASH
    && r_op == nsp_pkg::OP_READ && !q.lock[`NSP_LK_TBL]
    && sect_of(r_addr) == nsp_pkg::SEC_TBL |=> !nvm_go)
    else $error("read of a read-locked section was forwarded");

  c_chip_erase: cover property (@(posedge pclk) disable iff (!presetn)
    q.st == nsp_pkg::S_CE_LOCK);
  c_boot_write: cover property (@(posedge pclk) disable iff (!presetn)
    nvm_go && nvm_op == nsp_pkg::OP_WRITE && !q.owner);
  c_user_erase: cover property (@(posedge pclk) disable iff (!presetn)
    nvm_go && nvm_op == nsp_pkg::OP_ERASE_USER);
  c_cpu_denied: cover property (@(posedge pclk) disable iff (!presetn)
    cpu_denied);

endmodule : nsp_nvm_guard

// ==== sim/nsp_flash_model.sv ====
// Flash controller stand-in that answers the guard's orders.
module nsp_flash_model
(
  input  wire logic                pclk,
  input  wire logic                nvm_go,
  input  wire nsp_pkg::nsp_op_e    nvm_op,
  input  wire nsp_pkg::nsp_space_e nvm_space,
  input  wire logic [19:0]         nvm_addr,
  input  wire logic [15:0]         nvm_wdata,
  input  wire logic [7:0]          lat,
  output logic                     nvm_done,
  output logic      [15:0]         nvm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] fl [logic [19:0]];
  logic [15:0] us [logic [19:0]];
  nsp_pkg::nsp_op_e    o;
  nsp_pkg::nsp_space_e s;
  logic [19:0]         a;
  // Serves one order after lat cycles; erased words read all ones.
  initial
  begin
    nvm_done = 1'b0;
    nvm_rdata = 16'h0000;
    forever
    begin
      @(posedge pclk);
      nvm_done <= 1'b0;
      nvm_rdata <= ~nvm_rdata; // Idle data never looks valid.
      if (nvm_go === 1'b1)
      begin
        o = nvm_op;
        s = nvm_space;
        a = nvm_addr;
        if (o == nsp_pkg::OP_WRITE && s == nsp_pkg::SP_USER)
          us[a] = nvm_wdata;
        else if (o == nsp_pkg::OP_WRITE)
          fl[a] = nvm_wdata;
        else if (o == nsp_pkg::OP_CHIP_ERASE)
          fl.delete();
        else if (o == nsp_pkg::OP_ERASE_USER)
          us.delete();
        repeat (lat) @(posedge pclk);
        if (s == nsp_pkg::SP_USER)
          nvm_rdata <= us.exists(a) ? us[a] : 16'hffff;
        else
          nvm_rdata <= fl.exists(a) ? fl[a] : 16'hffff;
        nvm_done <= 1'b1;
      end
    end
  end
endmodule : nsp_flash_model

// ==== sim/tb_nvm_section_map_and_protection.sv ====
// Self-checking bench of the memory guard.
`include "nsp_consts.svh"
module tb_nvm_section_map_and_protection;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] DID = 24'h5a3c71; // Arbitrary value.
  localparam logic [7:0]  CO  = 8'h3c;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r32;
  logic cpu_req, cpu_ack, cpu_denied, e1, nvm_go, nvm_done;
  logic program_debug_port_req, program_debug_port_ack;
  logic program_debug_port_denied;
  nsp_pkg::nsp_op_e cpu_op, program_debug_port_op, nvm_op;
  nsp_pkg::nsp_space_e cpu_space, program_debug_port_space, nvm_space;
  logic [19:0] cpu_addr, cpu_fetch_pc, program_debug_port_addr, nvm_addr;
  logic [15:0] cpu_wdata, cpu_rdata, nvm_wdata, nvm_rdata, w, u;
  logic [15:0] program_debug_port_wdata, program_debug_port_rdata;
  logic [7:0] fuse_wdt, fuse_bod, fuse_startup, cal_osc, cal_adc, lat;
  logic [15:0] ds_addr;
  logic ds_rd, ds_wr, ds_io_sel, ds_ee_sel, ds_sram_sel;
  logic [7:0] ds_io_rdata, ds_ee_rdata, ds_sram_rdata, ds_rdata, x;
  int errors, compares, cyc, g;
  logic [15:0] dsa [9] = '{16'h0000, 16'h0fff, 16'h1000, 16'h17ff,
    16'h1800, 16'h1fff, 16'h2000, 16'h3fff, 16'h4000};

  nsp_nvm_guard #(.DEV_ID(DID), .CAL_OSC(CO)) u_dut (.*);
  nsp_flash_model u_fm (.*);

  // Free-running clock.
  always #4 pclk = ~pclk;

  task automatic chk(input string n, input logic [31:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s exp %h got %h", n, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r32 = prdata;
    e1 = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ar(input logic [11:0] a, input logic [23:0] xv,
                    input logic xe);
    apb(1'b0, a, 32'h0);
    chk("prdata", r32, xv);
    chk("pslverr", e1, xe);
  endtask : ar

  task automatic go(input logic p, input nsp_pkg::nsp_op_e o,
    input nsp_pkg::nsp_space_e s, input logic [19:0] a, pc,
    input logic [15:0] d, input logic xd, input logic [15:0] xr);
    @(posedge pclk);
    cpu_op <= o;
    program_debug_port_op <= o;
    cpu_space <= s;
    program_debug_port_space <= s;
    cpu_addr <= a;
    program_debug_port_addr <= a;
    cpu_wdata <= d;
    program_debug_port_wdata <= d;
    cpu_fetch_pc <= pc;
    cpu_req <= !p;
    program_debug_port_req <= p;
    repeat (300)
    begin
      @(posedge pclk);
      if (cpu_ack === 1'b1 || program_debug_port_ack === 1'b1) break;
    end
    chk("denied", p ? program_debug_port_denied : cpu_denied, xd);
    if (o == nsp_pkg::OP_READ)
      chk("rdata", p ? program_debug_port_rdata : cpu_rdata,
          xd ? 16'h0000 : xr);
    cpu_req <= 1'b0;
    program_debug_port_req <= 1'b0;
  endtask : go

  function automatic int rgn(input logic [15:0] a);
    if (a <= `NSP_IO_END) return 1;
    if (a >= `NSP_EE_START && a <= `NSP_EE_END) return 2;
    if (a >= `NSP_SRAM_START && a <= `NSP_SRAM_END) return 3;
    return 0;
  endfunction : rgn

  // Cuts a hung run short.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      print_verdict();
    end
  end

  // Main sequence.
  initial
  begin
    {pclk, psel, penable, pwrite, paddr, pwdata} = '0;
    {cpu_req, cpu_addr, cpu_wdata, cpu_fetch_pc, lat} = '0;
    {program_debug_port_req, program_debug_port_addr} = '0;
    program_debug_port_wdata = '0;
    cpu_op = nsp_pkg::OP_READ;
    program_debug_port_op = nsp_pkg::OP_READ;
    cpu_space = nsp_pkg::SP_FLASH;
    program_debug_port_space = nsp_pkg::SP_FLASH;
    {ds_addr, ds_rd, ds_wr, ds_io_rdata, ds_ee_rdata, ds_sram_rdata} = '0;
    presetn = 1'b0;
    void'($urandom(29557));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("fuse_wdt", fuse_wdt, 8'hff);
    chk("cal_osc", cal_osc, CO);
    ar(`NSP_REG_LOCK, 24'h0000ff, 1'b0);
    ar(`NSP_REG_DEVID, DID, 1'b0);
    ar(12'h010, 24'h0, 1'b1);
    go(0, nsp_pkg::OP_READ, nsp_pkg::SP_PSIG, 0, 0, 0, 0, DID[7:0]);
    go(1, nsp_pkg::OP_READ, nsp_pkg::SP_PSIG, 2, 0, 0, 0, DID[23:16]);
    go(1, nsp_pkg::OP_WRITE, nsp_pkg::SP_PSIG, 0, 0, 0, 1, 0);
    $display("test reset done");
    w = 16'($urandom);
    go(0, nsp_pkg::OP_WRITE, nsp_pkg::SP_FLASH, 'h100, 'h200, w, 1, 0);
    go(0, nsp_pkg::OP_WRITE, nsp_pkg::SP_FLASH, 'h100, 'h10004, w, 0, 0);
    go(0, nsp_pkg::OP_READ, nsp_pkg::SP_FLASH, 'h100, 0, 0, 0, w);
    lat = 8'd6;
    go(0, nsp_pkg::OP_WRITE, nsp_pkg::SP_FLASH, 'h10010, 'h10ffe, ~w, 0, 0);
    go(1, nsp_pkg::OP_READ, nsp_pkg::SP_FLASH, 'h10010, 0, 0, 0, ~w);
    lat = 8'd0;
    go(0, nsp_pkg::OP_WRITE, nsp_pkg::SP_FLASH, 'h11000, 'h10000, w, 1, 0);
    go(0, nsp_pkg::OP_WRITE, nsp_pkg::SP_FLASH, 'hf000, 'h10000, w, 0, 0);
    $display("test sections done");
    apb(1'b1, `NSP_REG_LOCK, 32'hfd);
    apb(1'b1, `NSP_REG_LOCK, 32'hff);
    ar(`NSP_REG_LOCK, 24'h0000fd, 1'b0);
    go(0, nsp_pkg::OP_WRITE, nsp_pkg::SP_FLASH, 'h100, 'h10000, w, 1, 0);
    go(0, nsp_pkg::OP_WRITE, nsp_pkg::SP_FLASH, 'hffff, 'h10000, w, 0, 0);
    apb(1'b1, `NSP_REG_LOCK, 32'hfb);
    go(1, nsp_pkg::OP_READ, nsp_pkg::SP_FLASH, 'hf000, 0, 0, 1, 0);
    go(1, nsp_pkg::OP_READ, nsp_pkg::SP_FLASH, 'h100, 0, 0, 0, w);
    $display("test locks done");
    x = 8'($urandom);
    go(0, nsp_pkg::OP_WRITE, nsp_pkg::SP_FUSE, 0, 0, {8'h0, x}, 1, 0);
    go(1, nsp_pkg::OP_WRITE, nsp_pkg::SP_FUSE, 0, 0, {8'h0, x}, 0, 0);
    chk("fuse_wdt", fuse_wdt, x);
    go(0, nsp_pkg::OP_READ, nsp_pkg::SP_FUSE, 0, 0, 0, 0, {8'h0, x});
    $display("test fuses done");
    u = 16'($urandom);
    go(1, nsp_pkg::OP_WRITE, nsp_pkg::SP_USER, 255, 0, u, 0, 0);
    go(0, nsp_pkg::OP_READ, nsp_pkg::SP_USER, 255, 0, 0, 0, u);
    go(0, nsp_pkg::OP_WRITE, nsp_pkg::SP_USER, 256, 0, u, 1, 0);
    go(0, nsp_pkg::OP_CHIP_ERASE, nsp_pkg::SP_FLASH, 0, 0, 0, 1, 0);
    lat = 8'd9;
    go(1, nsp_pkg::OP_CHIP_ERASE, nsp_pkg::SP_FLASH, 0, 0, 0, 0, 0);
    ar(`NSP_REG_LOCK, 24'h0000ff, 1'b0);
    go(1, nsp_pkg::OP_READ, nsp_pkg::SP_FLASH, 'h100, 0, 0, 0, 16'hffff);
    go(1, nsp_pkg::OP_READ, nsp_pkg::SP_USER, 255, 0, 0, 0, u);
    go(1, nsp_pkg::OP_ERASE_USER, nsp_pkg::SP_USER, 0, 0, 0, 0, 0);
    go(1, nsp_pkg::OP_READ, nsp_pkg::SP_USER, 255, 0, 0, 0, 16'hffff);
    ar(`NSP_REG_STATUS, 24'h802, 1'b0);
    $display("test erase done");
    ds_io_rdata <= 8'($urandom);
    ds_ee_rdata <= 8'($urandom);
    ds_sram_rdata <= 8'($urandom);
    foreach (dsa[i])
    begin
      @(posedge pclk);
      ds_addr <= dsa[i];
      ds_rd <= 1'b1;
      @(posedge pclk);
      g = rgn(dsa[i]);
      chk("ds_io_sel", ds_io_sel, g == 1);
      chk("ds_ee_sel", ds_ee_sel, g == 2);
      chk("ds_sram_sel", ds_sram_sel, g == 3);
      ds_rd <= 1'b0;
      @(posedge pclk);
      chk("ds_rdata", ds_rdata, g == 1 ? ds_io_rdata : g == 2 ?
          ds_ee_rdata : g == 3 ? ds_sram_rdata : 8'h00);
    end
    $display("test data space done");
    print_verdict();
  end
endmodule : tb_nvm_section_map_and_protection
